//--- core/dbl_top.sv
// Purpose: DMA buffer level, pointers and bulk packet count for two channels
// Assumes: single 40 MHz clock, Avalon-MM slave, synchronous inputs
// Notes: channel 0 carries the bulk path through the FIFO to the codec port
//
// Overview of operation
// - per channel read-only 16-bit fill level bytes
// - fill level latched at each start-of-frame
// - 16-bit read/write bulk packet count bytes
// - up to 65535 packets without firmware action
// - count readable anytime, read leaves it alone
// - write pointer exposed as low and high bytes
// - write pointer high bits 7:3 reserved
// - read pointer low byte per channel
// - pointers readable by firmware at any time
// - read pointer upper three bits high byte
// - handshake mode stops, disables, flags done
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module dbl_top
  import dbl_pkg::*;
#(
  parameter int FIFO_DEPTH = DBL_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // avalon-mm slave, byte address
  input wire logic [DBL_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // usb side events
  input wire logic sof,
  input wire logic ch0_wr_advance,
  input wire logic ch1_wr_advance,
  input wire logic ch1_rd_advance,
  // bulk data from buffer manager into channel 0
  input wire logic bulk_valid,
  output logic bulk_ready,
  input wire logic [7:0] bulk_data,
  input wire logic bulk_last,
  // codec port side
  output logic cport_valid,
  input wire logic cport_ready,
  output logic [7:0] cport_data,
  output logic channel_done
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [DBL_PTR_W-1:0] wr_ptr_reg [2];
  logic [DBL_PTR_W-1:0] rd_ptr_reg [2];
  logic [DBL_CNT_W-1:0] fill_reg [2];
  logic [DBL_CNT_W-1:0] pkt_cnt_reg;
  logic en_reg;
  logic hsk_reg;
  logic done_reg;
  logic rd_pend_reg;
  logic [31:0] rdata_reg;

  function automatic logic [DBL_PTR_W-1:0] ptr_inc(input logic [DBL_PTR_W-1:0] p);
    ptr_inc = p + 11'h001;
  endfunction

  // live byte count between write and read pointers, modulo buffer size
  function automatic logic [DBL_CNT_W-1:0] level_of(input logic [DBL_PTR_W-1:0] w,
                                                    input logic [DBL_PTR_W-1:0] r);
    logic [DBL_PTR_W-1:0] d;
    d = w - r;
    level_of = {5'h00, d};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bulk path through the fifo
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  wire logic running = en_reg && (pkt_cnt_reg != DBL_CNT_RST);
  // stall upstream while the channel is stopped
  wire logic accept = bulk_valid && fifo_in_ready && running;
  wire logic take = fifo_out_valid && cport_ready;
  wire logic pkt_end = accept && bulk_last;

  assign bulk_ready = fifo_in_ready && running;
  assign cport_valid = fifo_out_valid;
  assign cport_data = fifo_out_data;

  dbl_fifo #(.WIDTH(DBL_FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .in_valid(accept),
    .in_ready(fifo_in_ready),
    .in_data(bulk_data),
    .out_valid(fifo_out_valid),
    .out_ready(cport_ready),
    .out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire logic [15:0] reg_idx = avs_address[17:2];
  wire logic hit_rd = avs_read && !rd_pend_reg;
  wire logic wr_lo = avs_write && (reg_idx == DBL_BPC_LO) && avs_byteenable[0];
  wire logic wr_hi = avs_write && (reg_idx == DBL_BPC_HI) && avs_byteenable[0];
  wire logic wr_ctrl = avs_write && (reg_idx == DBL_CTRL) && avs_byteenable[0];
  wire logic [7:0] ctrl_rd = {5'h00, done_reg, hsk_reg, en_reg};
  wire logic last_pkt = (pkt_cnt_reg == 16'h0001);

  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_byte = DBL_BYTE_RST;
    rd_hit = 1'b1;
    unique case (reg_idx)
      DBL_CH0_FILL_LO: rd_byte = fill_reg[0][7:0];
      DBL_CH0_FILL_HI: rd_byte = fill_reg[0][15:8];
      DBL_CH1_FILL_LO: rd_byte = fill_reg[1][7:0];
      DBL_CH1_FILL_HI: rd_byte = fill_reg[1][15:8];
      DBL_BPC_LO: rd_byte = pkt_cnt_reg[7:0];
      DBL_BPC_HI: rd_byte = pkt_cnt_reg[15:8];
      DBL_CH0_WR_LO: rd_byte = wr_ptr_reg[0][7:0];
      DBL_CH0_WR_HI: rd_byte = {5'h00, wr_ptr_reg[0][10:8]};
      DBL_CH1_WR_LO: rd_byte = wr_ptr_reg[1][7:0];
      DBL_CH1_WR_HI: rd_byte = {5'h00, wr_ptr_reg[1][10:8]};
      DBL_CH0_RD_LO: rd_byte = rd_ptr_reg[0][7:0];
      DBL_CH1_RD_LO: rd_byte = rd_ptr_reg[1][7:0];
      DBL_CH0_RD_HI: rd_byte = {5'h00, rd_ptr_reg[0][10:8]};
      DBL_CH1_RD_HI: rd_byte = {5'h00, rd_ptr_reg[1][10:8]};
      DBL_CTRL: rd_byte = ctrl_rd;
      default: rd_hit = 1'b0;
    endcase
  end

  // reads take one extra cycle so read data come from a flop
  assign avs_waitrequest = avs_read && !rd_pend_reg;
  assign avs_readdata = rdata_reg;
  assign channel_done = done_reg;

  ////////////////////////////////////////////////////////////////////////////
  // bus read pipeline
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend_reg <= 1'b0;
      rdata_reg <= DBL_UNMAPPED;
    end else if (ce) begin
      rd_pend_reg <= hit_rd;
      if (hit_rd) begin
        rdata_reg <= rd_hit ? {24'h000000, rd_byte} : DBL_UNMAPPED;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointers and frame-latched fill level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 2; i++) begin
        wr_ptr_reg[i] <= DBL_PTR_RST;
        rd_ptr_reg[i] <= DBL_PTR_RST;
        fill_reg[i] <= DBL_CNT_RST;
      end
    end else if (ce) begin
      if (ch0_wr_advance) wr_ptr_reg[0] <= ptr_inc(wr_ptr_reg[0]);
      if (ch1_wr_advance) wr_ptr_reg[1] <= ptr_inc(wr_ptr_reg[1]);
      if (take) rd_ptr_reg[0] <= ptr_inc(rd_ptr_reg[0]);
      if (ch1_rd_advance) rd_ptr_reg[1] <= ptr_inc(rd_ptr_reg[1]);
      if (sof) begin
        // held for the whole frame so firmware sees a stable value
        fill_reg[0] <= level_of(wr_ptr_reg[0], rd_ptr_reg[0]);
        fill_reg[1] <= level_of(wr_ptr_reg[1], rd_ptr_reg[1]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // packet count and channel control
  // a packet counts once its last byte enters the fifo; count writes are dropped
  // while enabled, and a decrement wins over a load in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pkt_cnt_reg <= DBL_CNT_RST;
      en_reg <= 1'b0;
      hsk_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (ce) begin
      if (pkt_end) begin
        pkt_cnt_reg <= pkt_cnt_reg - 16'h0001;
      end else if (wr_lo && !en_reg) begin
        pkt_cnt_reg[7:0] <= avs_writedata[7:0];
      end else if (wr_hi && !en_reg) begin
        pkt_cnt_reg[15:8] <= avs_writedata[7:0];
      end
      if (pkt_end && last_pkt && hsk_reg) begin
        en_reg <= 1'b0;
      end else if (wr_ctrl) begin
        en_reg <= avs_writedata[DBL_CTRL_EN];
      end
      if (wr_ctrl && !en_reg) hsk_reg <= avs_writedata[DBL_CTRL_HSK];
      // set wins over a clearing write in the same cycle
      if (pkt_end && last_pkt) begin
        done_reg <= 1'b1;
      end else if (wr_ctrl && avs_writedata[DBL_CTRL_DONE]) begin
        done_reg <= 1'b0;
      end
    end
  end
endmodule

//--- core/dbl_pkg.sv
// Purpose: constants shared by the DMA buffer level and packet count block
// Assumes: Avalon-MM slave with 32-bit data, one register per aligned word
// Notes: printed offsets are not all multiples of four, so byte address = 4 * index
package dbl_pkg;
  localparam int DBL_ADDR_W = 18;
  localparam int DBL_PTR_W = 11;
  localparam int DBL_CNT_W = 16;
  localparam int DBL_FIFO_DEPTH = 32;
  localparam int DBL_FIFO_W = 8;
  // register indices as printed
  localparam logic [15:0] DBL_CH1_RD_LO = 16'hFFB6;
  localparam logic [15:0] DBL_CH1_WR_HI = 16'hFFB7;
  localparam logic [15:0] DBL_CH1_WR_LO = 16'hFFB8;
  localparam logic [15:0] DBL_CH0_RD_HI = 16'hFFB9;
  localparam logic [15:0] DBL_CH0_RD_LO = 16'hFFBA;
  localparam logic [15:0] DBL_CH0_WR_HI = 16'hFFBB;
  localparam logic [15:0] DBL_CH0_WR_LO = 16'hFFBC;
  localparam logic [15:0] DBL_CH1_RD_HI = 16'hFFB5;
  localparam logic [15:0] DBL_CH0_FILL_LO = 16'hFFEB;
  localparam logic [15:0] DBL_CH0_FILL_HI = 16'hFFEC;
  localparam logic [15:0] DBL_BPC_HI = 16'hFFF1;
  localparam logic [15:0] DBL_BPC_LO = 16'hFFF2;
  localparam logic [15:0] DBL_CH1_FILL_LO = 16'hFFF3;
  localparam logic [15:0] DBL_CH1_FILL_HI = 16'hFFF4;
  // control register of our own: bit0 enable, bit1 handshake, bit2 done (read)
  localparam logic [15:0] DBL_CTRL = 16'hFF80;
  localparam int DBL_CTRL_EN = 0;
  localparam int DBL_CTRL_HSK = 1;
  localparam int DBL_CTRL_DONE = 2;
  localparam logic [7:0] DBL_BYTE_RST = 8'h00;
  localparam logic [15:0] DBL_CNT_RST = 16'h0000;
  localparam logic [10:0] DBL_PTR_RST = 11'h000;
  localparam logic [31:0] DBL_UNMAPPED = 32'h0000_0000;
endpackage

//--- core/dbl_mem.sv
// Purpose: small byte memory with registered read data
// Assumes: one write and one read port, same clock
// Notes: read data valid the cycle after the read request
`timescale 1ns/1ps
module dbl_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
    if (ce && rd_en) begin
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule

//--- core/dbl_fifo.sv
// Purpose: valid/ready byte FIFO between the buffer manager and the codec port
// Assumes: first-word fall-through through a one-entry output register
// Notes: full and empty are exact, counted on stored entries
`timescale 1ns/1ps
module dbl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic out_valid_reg;
  logic [WIDTH-1:0] mem_q;
  wire logic full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                    (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire logic empty = (wr_ptr_reg == rd_ptr_reg);
  wire logic push = in_valid && !full;
  // load the output stage when it is free or being taken
  wire logic pop = !empty && (!out_valid_reg || out_ready);

  assign in_ready = !full;
  assign out_valid = out_valid_reg;
  assign out_data = mem_q;

  dbl_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
    .clk(clk),
    .ce(ce),
    .wr_en(push),
    .wr_addr(wr_ptr_reg[AW-1:0]),
    .wr_data(in_data),
    .rd_en(pop),
    .rd_addr(rd_ptr_reg[AW-1:0]),
    .rd_data(mem_q)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      out_valid_reg <= 1'b0;
    end else if (ce) begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (pop) out_valid_reg <= 1'b1;
      else if (out_ready) out_valid_reg <= 1'b0;
    end
  end
endmodule

//--- bench/dbl_asserts.sv
// Purpose: port checks for dbl_top
// Assumes: ce held high by the bench
// Notes: sees only the top ports
`timescale 1ns/1ps
module dbl_asserts
  import dbl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [DBL_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic bulk_ready,
  input wire logic cport_valid,
  input wire logic cport_ready,
  input wire logic [7:0] cport_data,
  input wire logic channel_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire ctrl_hit = avs_address == {DBL_CTRL, 2'b00};
  wire done_clr = avs_write && ctrl_hit && avs_writedata[2] && avs_byteenable[0];
  ////////////////////////////////////////////////////////////
  sequence s_rd_wait;
    avs_read && avs_waitrequest && ce;
  endsequence
  sequence s_rd_ans;
    !avs_waitrequest && avs_readdata[31:8] == 24'h000000;
  endsequence
  a_read_one_wait: assert property (s_rd_wait |=> s_rd_ans)
    else $error("read answer late");
  a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  a_idle_no_wait: assert property (!avs_read |-> !avs_waitrequest)
    else $error("wait without read");
  a_hi_bits_zero: assert property (
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_cport_hold: assert property (
    cport_valid && !cport_ready |=> cport_valid && $stable(cport_data))
    else $error("codec byte dropped");
  a_done_stops: assert property ($rose(channel_done) |-> !bulk_ready)
    else $error("ready after done");
  a_done_sticky: assert property (channel_done && !done_clr |=> channel_done)
    else $error("done lost");
  a_release_quiet: assert property ($rose(rst_b) |-> !channel_done && !cport_valid)
    else $error("busy after reset");
endmodule

//--- bench/dbl_partner.sv
// Purpose: buffer manager and codec port stand-in
// Assumes: packets pushed through send_pkt
// Notes: slow mode halves codec throughput
`timescale 1ns/1ps
module dbl_partner (
  input wire logic clk,
  input wire logic stall,
  input wire logic slow,
  output logic bulk_valid,
  input wire logic bulk_ready,
  output logic [7:0] bulk_data,
  output logic bulk_last,
  input wire logic cport_valid,
  output logic cport_ready,
  input wire logic [7:0] cport_data
);
  logic [7:0] rx_q[$];
  initial begin
    bulk_valid = 1'b0;
    bulk_data = 8'h00;
    bulk_last = 1'b0;
    cport_ready = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // whole packet, no pause for firmware between packets
  task automatic send_pkt(input int len, input logic [7:0] base);
    for (int i = 0; i < len; i++) begin
      bulk_valid <= 1'b1;
      bulk_data <= base + 8'(i);
      bulk_last <= (i == len - 1);
      // the byte is taken at the edge where ready stood high before it
      @(posedge clk iff bulk_ready);
    end
    bulk_valid <= 1'b0;
    bulk_last <= 1'b0;
    // released data must not look like the last byte
    bulk_data <= ~bulk_data;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cport_ready <= !stall && (!slow || !cport_ready);
    if (cport_valid && cport_ready) rx_q.push_back(cport_data);
  end
endmodule

//--- bench/dbl_top_tb.sv
// Purpose: self-checking bench for dbl_top
// Assumes: ce and byte enables tied on
// Notes: three handshake packets, the first overfills the fifo
`timescale 1ns/1ps
module dbl_top_tb;
  import dbl_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [17:0] avs_address = 18'h00000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic sof = 1'b0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic [2:0] adv = 3'h0;
  logic avs_waitrequest, bulk_valid, bulk_ready, bulk_last, cport_valid, cport_ready, done;
  logic [7:0] bulk_data, cport_data, d;
  integer seed = 32'h8BAC;
  int err_count = 0, compares = 0, cycles = 0, wp0 = 0, wp1 = 0, rp0 = 0, rp1 = 0;
  int n, f0, f1;
  logic [7:0] exp_q[$];
  logic [15:0] regs[13] = '{DBL_CH1_RD_LO, DBL_CH1_WR_HI, DBL_CH1_WR_LO, DBL_CH0_RD_HI,
    DBL_CH0_RD_LO, DBL_CH0_WR_HI, DBL_CH0_WR_LO, DBL_CH1_RD_HI, DBL_CH0_FILL_LO,
    DBL_CH0_FILL_HI, DBL_CH1_FILL_LO, DBL_CH1_FILL_HI, 16'hFF00};
  always #12.5 clk = ~clk;
  dbl_top dut_u (.clk(clk), .rst_b(rst_b), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sof(sof), .ch0_wr_advance(adv[0]), .ch1_wr_advance(adv[1]), .ch1_rd_advance(adv[2]),
    .bulk_valid(bulk_valid), .bulk_ready(bulk_ready), .bulk_data(bulk_data),
    .bulk_last(bulk_last), .cport_valid(cport_valid), .cport_ready(cport_ready),
    .cport_data(cport_data), .channel_done(done));
  dbl_partner partner_u (.clk(clk), .stall(stall), .slow(slow), .bulk_valid(bulk_valid),
    .bulk_ready(bulk_ready), .bulk_data(bulk_data), .bulk_last(bulk_last),
    .cport_valid(cport_valid), .cport_ready(cport_ready), .cport_data(cport_data));
  ////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input int e);
    compares++;
    if (got !== e[7:0]) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, e[7:0]);
    end
  endtask
  task automatic rd(input logic [15:0] idx, input int e);
    avs_address <= {idx, 2'b00};
    avs_read <= 1'b1;
    // sample waitrequest as it stood at the edge, not after the flops moved
    @(posedge clk iff !avs_waitrequest);
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
    @(posedge clk);
    chk(d, e);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] v);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, v};
    avs_write <= 1'b1;
    @(posedge clk iff !avs_waitrequest);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic bump(input int w, input int k);
    for (int i = 0; i < k; i++) begin
      adv <= 3'(1 << w);
      @(posedge clk);
    end
    adv <= 3'h0;
    @(posedge clk);
  endtask
  task automatic ptr(input logic [15:0] lo, input logic [15:0] hi, input int v);
    rd(lo, v & 255);
    rd(hi, (v >> 8) & 7);
  endtask
  task automatic tick_sof();
    f0 = (wp0 - rp0) & 2047;
    f1 = (wp1 - rp1) & 2047;
    sof <= 1'b1;
    @(posedge clk);
    sof <= 1'b0;
    @(posedge clk);
  endtask
  task automatic fills();
    rd(DBL_CH0_FILL_LO, f0);
    rd(DBL_CH0_FILL_HI, f0 >> 8);
    rd(DBL_CH1_FILL_LO, f1);
    rd(DBL_CH1_FILL_HI, f1 >> 8);
  endtask
  task automatic q_pkt(input int len, input int base);
    for (int i = 0; i < len; i++) exp_q.push_back(8'(base + i));
    partner_u.send_pkt(len, 8'(base));
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (regs[i]) begin
      rd(regs[i], 0);
      wr(regs[i], 8'($random(seed)));
      rd(regs[i], 0);
    end
    n = $random(seed);
    rd(DBL_BPC_HI, 0);
    wr(DBL_BPC_LO, n[7:0]);
    wr(DBL_BPC_HI, n[15:8]);
    rd(DBL_BPC_LO, n);
    rd(DBL_BPC_HI, n >> 8);
    n = 2040 + ($random(seed) & 15);
    bump(1, n);
    wp1 += n;
    n = $random(seed) & 511;
    bump(2, n);
    rp1 += n;
    n = $random(seed) & 511;
    bump(0, n);
    wp0 += n;
    ptr(DBL_CH1_WR_LO, DBL_CH1_WR_HI, wp1);
    ptr(DBL_CH1_RD_LO, DBL_CH1_RD_HI, rp1);
    ptr(DBL_CH0_WR_LO, DBL_CH0_WR_HI, wp0);
    tick_sof();
    bump(1, 7);
    wp1 += 7;
    fills();
    tick_sof();
    fills();
    // count goes in before enable, later writes while running are dropped
    wr(DBL_BPC_HI, 8'h00);
    wr(DBL_BPC_LO, 8'h03);
    wr(DBL_CTRL, 8'h03);
    wr(DBL_BPC_LO, 8'h77);
    stall <= 1'b1;
    fork
      q_pkt(40, 16);
    join_none
    n = 0;
    while (bulk_ready !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk({7'h00, bulk_ready}, 0);
    rd(DBL_BPC_LO, 3);
    stall <= 1'b0;
    slow <= 1'b1;
    wait fork;
    for (int p = 1; p < 3; p++) q_pkt(1 + ($random(seed) & 7), p * 64);
    n = 0;
    while (partner_u.rx_q.size() < exp_q.size() && n < 500) begin
      @(posedge clk);
      n++;
    end
    rp0 = exp_q.size();
    chk(8'(partner_u.rx_q.size()), rp0);
    foreach (exp_q[i]) chk(partner_u.rx_q[i], exp_q[i]);
    rd(DBL_BPC_LO, 0);
    rd(DBL_CTRL, 8'h06);
    ptr(DBL_CH0_RD_LO, DBL_CH0_RD_HI, rp0);
    tick_sof();
    fills();
    wr(DBL_CTRL, 8'h04);
    chk({7'h00, done}, 0);
    wrap_up();
  end
endmodule
bind dbl_top dbl_asserts chk_u (.clk(clk), .rst_b(rst_b), .ce(ce), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .bulk_ready(bulk_ready), .cport_valid(cport_valid),
  .cport_ready(cport_ready), .cport_data(cport_data), .channel_done(channel_done));
